// *** hw/chr_can_hist_ts.v ***
`timescale 1ns/100ps
`include "chr_regs.vh"
// How it works
// RL1: rx port upper byte returns get-pointer entry
// RL2: rx match flag set when nothing unread
// RL3: rx overflow at 23; later entries overwrite
// RL4: overflowed stores leave rx match untouched
// RL5: write one to bit0 clears rx overflow
// RL6: tx last register returns last transmitted buffer
// RL7: tx last undefined after match following init
// RL8: tx port bits 15:8 return get-pointer entry
// RL9: tx match bit1 set when nothing unread
// RL10: tx overflow at 7; later entries overwrite
// RL11: overflowed transmissions leave tx match untouched
// RL12: write one to bit0 clears tx overflow
// RL13: auto block mode skips buffers 0..7
// RL14: select bit picks start or end frame
// RL15: enable lets stamp output toggle per event
// RL16: lock freezes output on buffer0 data receive
// RL17: software avoids lock with auto block transmit
// RL18: set upper byte, clear lower byte pairs
// RL19: stamp control resets to zero
// RL20: payload as halfwords and bytes, undefined reset
// RL21: rx last register reports last stored buffer
// RL22: rx read port at index 060
// RL23: port read advances pointer when unread entries
module chr_can_hist_ts (
    // clock, reset, enable
    input  wire        core_clk_in,
    input  wire        resetn_in,
    input  wire        clk_en_in,
    // apb slave
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [13:0] paddr_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output reg         pready_out,
    output reg         pslverr_out,
    // protocol engine events (same clock)
    input  wire        rx_store_in,
    input  wire        rx_data_frame_in,
    input  wire [4:0]  rx_buf_in,
    input  wire        tx_done_in,
    input  wire [4:0]  tx_buf_in,
    input  wire        auto_block_transmit_in,
    input  wire        sof_event_in,
    input  wire        eof_event_in,
    // time stamp pin
    output reg         stamp_toggle_output_out
);
    ////////////////////////////////////////////////////////////////////////
    reg  [2:0]  ts_q;
    reg  [15:0] payload_q [0:3];
    wire [11:0] idx   = paddr_in[13:2];
    wire        acc   = psel_in & penable_in & ~pready_out;
    wire        wr    = acc & pwrite_in;
    wire        rd    = acc & ~pwrite_in;
    wire [15:0] wd    = pwdata_in[15:0];
    wire [11:0] pidx  = idx - `CHR_IDX_PAYLOAD_BASE;
    wire        is_pl = (idx >= `CHR_IDX_PAYLOAD_BASE) &&
                        (idx <  `CHR_IDX_PAYLOAD_BASE + `CHR_PAYLOAD_SLOTS);

    function mapped;
        input [11:0] i;
        input        p;
        begin
            mapped = p || i == `CHR_IDX_RX_LAST || i == `CHR_IDX_RX_PORT ||
                     i == `CHR_IDX_TX_LAST || i == `CHR_IDX_TX_PORT || i == `CHR_IDX_TS_CTRL;
        end
    endfunction

    function [2:0] setclr;
        input [2:0]  cur;
        input [15:0] w;
        integer k;
        begin
            setclr = cur;
            for (k = 0; k < 3; k = k + 1) begin
                if (w[k + `CHR_TS_SET_SHIFT] && !w[k])
                    setclr[k] = 1'b1;
                else if (!w[k + `CHR_TS_SET_SHIFT] && w[k])
                    setclr[k] = 1'b0;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    wire [4:0] rx_head;
    wire [4:0] rx_last;
    wire       rx_match;
    wire       rx_ovf;
    wire [4:0] tx_head;
    wire [4:0] tx_last;
    wire       tx_match;
    wire       tx_ovf;
    // in auto block mode buffers 0..7 belong to the auto block sequence and are kept out of the list
    wire tx_push = tx_done_in & ~(auto_block_transmit_in & (tx_buf_in <= `CHR_ABT_LOW_LIMIT)); // [RL13]

    chr_hist_list #(.DEPTH(`CHR_RX_DEPTH), .PW(5)) u_rx (
        .clk_in       (core_clk_in),
        .rst_n_in     (resetn_in),
        .ce_in        (clk_en_in),
        .push_in      (rx_store_in),                                      // [RL3] [RL4]
        .num_in       (rx_buf_in),
        .pop_in       (rd && idx == `CHR_IDX_RX_PORT),                    // [RL23]
        .clr_ovf_in   (wr && idx == `CHR_IDX_RX_PORT && wd[`CHR_BIT_OVF]), // [RL5]
        .head_num_out (rx_head),
        .last_num_out (rx_last),
        .match_out    (rx_match),
        .ovf_out      (rx_ovf)
    );

    chr_hist_list #(.DEPTH(`CHR_TX_DEPTH), .PW(3)) u_tx (
        .clk_in       (core_clk_in),
        .rst_n_in     (resetn_in),
        .ce_in        (clk_en_in),
        .push_in      (tx_push),                                          // [RL10] [RL11]
        .num_in       (tx_buf_in),
        .pop_in       (rd && idx == `CHR_IDX_TX_PORT),                    // [RL23]
        .clr_ovf_in   (wr && idx == `CHR_IDX_TX_PORT && wd[`CHR_BIT_OVF]), // [RL12]
        .head_num_out (tx_head),
        .last_num_out (tx_last),
        .match_out    (tx_match),
        .ovf_out      (tx_ovf)
    );

    ////////////////////////////////////////////////////////////////////////
    // read mux
    reg [15:0] rdat;
    always @* begin
        rdat = 16'h0000;
        if (is_pl) begin
            if (pidx < 12'h004)
                rdat = payload_q[pidx[1:0]];                             // [RL20]
            else
                rdat = {8'h00, pidx[0] ? payload_q[pidx[2:1] - 2'h2][15:8]
                                       : payload_q[pidx[2:1] - 2'h2][7:0]};
        end else begin
            case (idx)
                `CHR_IDX_RX_LAST: rdat = {11'h000, rx_last};              // [RL21]
                `CHR_IDX_RX_PORT: rdat = {3'h0, rx_head, 6'h00, rx_match, rx_ovf}; // [RL1] [RL2] [RL22]
                `CHR_IDX_TX_LAST: rdat = {11'h000, tx_last};              // [RL6] [RL7]
                `CHR_IDX_TX_PORT: rdat = {3'h0, tx_head, 6'h00, tx_match, tx_ovf}; // [RL8] [RL9]
                `CHR_IDX_TS_CTRL: rdat = {13'h0000, ts_q};
                default:          rdat = 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // payload storage: no reset, contents undefined until written
    always @(posedge core_clk_in) begin
        if (clk_en_in && wr && is_pl) begin
            if (pidx < 12'h004)
                payload_q[pidx[1:0]] <= wd;                              // [RL20]
            else if (pidx[0])
                payload_q[pidx[2:1] - 2'h2][15:8] <= wd[7:0];
            else
                payload_q[pidx[2:1] - 2'h2][7:0] <= wd[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // time stamp; lock must not be combined with auto block transmit by software [RL17]
    wire ts_event = ts_q[`CHR_BIT_TS_SEL] ? eof_event_in : sof_event_in; // [RL14]
    wire ts_lock  = ts_q[`CHR_BIT_TS_LOCK] & rx_store_in & rx_data_frame_in & (rx_buf_in == 5'h00);
    reg  [2:0] ts_d;
    always @* begin
        ts_d = ts_q;
        if (wr && idx == `CHR_IDX_TS_CTRL)
            ts_d = setclr(ts_q, wd);                                     // [RL18]
        if (ts_lock)
            ts_d[`CHR_BIT_TS_EN] = 1'b0;                                 // [RL16]
    end

    always @(posedge core_clk_in) begin
        if (!resetn_in) begin
            ts_q                    <= `CHR_TS_RESET;                    // [RL19]
            stamp_toggle_output_out <= 1'b0;
            prdata_out              <= 32'h00000000;
            pready_out              <= 1'b0;
            pslverr_out             <= 1'b0;
        end else if (clk_en_in) begin
            ts_q <= ts_d;
            if (ts_event && ts_q[`CHR_BIT_TS_EN] && !ts_lock)
                stamp_toggle_output_out <= ~stamp_toggle_output_out;     // [RL15]
            pready_out  <= acc;
            pslverr_out <= acc & ~mapped(idx, is_pl);
            prdata_out  <= rd ? {16'h0000, rdat} : 32'h00000000;
        end
    end
endmodule // chr_can_hist_ts

// *** hw/chr_hist_list.v ***
`timescale 1ns/100ps
// circular history list of buffer numbers with overflow handling
module chr_hist_list #(
    parameter DEPTH = 23,
    parameter PW    = 5
) (
    // clock, reset, enable
    input  wire          clk_in,
    input  wire          rst_n_in,
    input  wire          ce_in,
    // event side
    input  wire          push_in,
    input  wire [4:0]    num_in,
    // software side
    input  wire          pop_in,
    input  wire          clr_ovf_in,
    // state
    output wire [4:0]    head_num_out,
    output wire [4:0]    last_num_out,
    output reg           match_out,
    output reg           ovf_out
);
    reg  [4:0]    mem [0:DEPTH-1];
    reg  [PW-1:0] wr_q;
    reg  [PW-1:0] rd_q;
    reg  [PW-1:0] cnt_q;

    localparam [31:0] LAST_W = DEPTH - 1;

    function [PW-1:0] nxt;
        input [PW-1:0] p;
        begin
            nxt = (p == LAST_W[PW-1:0]) ? {PW{1'b0}} : p + 1'b1;
        end
    endfunction

    function [PW-1:0] prv;
        input [PW-1:0] p;
        begin
            prv = (p == {PW{1'b0}}) ? LAST_W[PW-1:0] : p - 1'b1;
        end
    endfunction

    // cnt_q must be wide enough to hold DEPTH itself
    wire [PW-1:0] last_pos = prv(wr_q);
    wire          full     = (cnt_q == DEPTH);
    // after overflow every new number lands on the last-in slot, so the first DEPTH-1 stay in order
    wire          hold_wr  = ovf_out | full;
    wire          grow     = push_in & ~hold_wr;
    wire          do_pop   = pop_in & ~match_out;

    assign head_num_out = mem[rd_q];
    assign last_num_out = mem[last_pos];

    always @(posedge clk_in) begin
        if (ce_in && push_in) begin
            if (hold_wr)
                mem[last_pos] <= num_in;
            else
                mem[wr_q] <= num_in;
        end
    end

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_q      <= {PW{1'b0}};
            rd_q      <= {PW{1'b0}};
            cnt_q     <= {PW{1'b0}};
            match_out <= 1'b1;
            ovf_out   <= 1'b0;
        end else if (ce_in) begin
            if (grow)
                wr_q <= nxt(wr_q);
            if (do_pop)
                rd_q <= nxt(rd_q);
            // last unread number leaves and nothing new is added
            if (do_pop && cnt_q == 1 && !grow)
                match_out <= 1'b1;
            else if (push_in && !ovf_out)
                match_out <= 1'b0;
            if (grow && !do_pop)
                cnt_q <= cnt_q + 1'b1;
            else if (do_pop && !grow)
                cnt_q <= cnt_q - 1'b1;
            // the filling push and every later one set the flag; set wins over clear
            if (push_in && (ovf_out || cnt_q >= DEPTH - 1))
                ovf_out <= 1'b1;
            else if (clr_ovf_in)
                ovf_out <= 1'b0;
        end
    end
endmodule // chr_hist_list

// *** hw/chr_regs.vh ***
`ifndef CHR_REGS_VH
`define CHR_REGS_VH
// register indices, one word each: byte address = 4 * index
`define CHR_IDX_RX_LAST      12'h05e
`define CHR_IDX_RX_PORT      12'h060
`define CHR_IDX_TX_LAST      12'h062
`define CHR_IDX_TX_PORT      12'h064
`define CHR_IDX_TS_CTRL      12'h066
// message payload registers: pairs at base+0..3, bytes at base+4..11
`define CHR_IDX_PAYLOAD_BASE 12'h070
`define CHR_PAYLOAD_SLOTS    12
// field positions
`define CHR_BIT_OVF          0
`define CHR_BIT_MATCH        1
`define CHR_BIT_TS_EN        0
`define CHR_BIT_TS_SEL       1
`define CHR_BIT_TS_LOCK      2
`define CHR_TS_SET_SHIFT     8
// reset values
`define CHR_TS_RESET         3'h0
// list geometry
`define CHR_RX_KEEP          22
`define CHR_TX_KEEP          6
`define CHR_RX_DEPTH         23
`define CHR_TX_DEPTH         7
`define CHR_ABT_LOW_LIMIT    5'h07
`endif

// *** verification/chr_hist_ts_monitor.sv ***
`timescale 1ns/100ps
module chr_hist_ts_monitor (
    // clock and reset
    input wire        core_clk_in,
    input wire        resetn_in,
    // apb
    input wire        psel_in,
    input wire        penable_in,
    input wire        pwrite_in,
    input wire [13:0] paddr_in,
    input wire [31:0] prdata_out,
    input wire        pready_out,
    input wire        pslverr_out,
    // stamp
    input wire        sof_event_in,
    input wire        eof_event_in,
    input wire        stamp_toggle_output_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    wire rd = pready_out && !pwrite_in;
    wire ev = sof_event_in || eof_event_in;
    chk_ready_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
        else $error("ready late");
    chk_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("ready held");
    chk_err_with_ready: assert property (pslverr_out |-> pready_out)
        else $error("stray error");
    chk_rx_port_ok: assert property (pready_out && paddr_in == 14'h180 |-> !pslverr_out)
        else $error("rx port refused");
    chk_rx_fields: assert property (rd && paddr_in == 14'h180 |-> prdata_out[31:13] == 0 && prdata_out[7:2] == 0)
        else $error("rx port fields");
    chk_tx_fields: assert property (rd && paddr_in == 14'h190 |-> prdata_out[31:13] == 0 && prdata_out[7:2] == 0)
        else $error("tx port fields");
    chk_ts_fields: assert property (rd && paddr_in == 14'h198 |-> prdata_out[31:3] == 0)
        else $error("stamp fields");
    chk_last_fields: assert property (rd && paddr_in == 14'h188 |-> prdata_out[31:5] == 0 && !pslverr_out)
        else $error("tx last fields");
    chk_stamp_cause: assert property ($changed(stamp_toggle_output_out) |-> $past(ev) || $past(ev, 2))
        else $error("stamp moved alone");
    cov_toggle: cover property ($changed(stamp_toggle_output_out));
    cov_err: cover property (pslverr_out);
    cov_rx_entry: cover property (rd && paddr_in == 14'h180 && !prdata_out[1]);
endmodule // chr_hist_ts_monitor

bind chr_can_hist_ts chr_hist_ts_monitor i_chr_hist_ts_monitor (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .sof_event_in(sof_event_in),
    .eof_event_in(eof_event_in), .stamp_toggle_output_out(stamp_toggle_output_out));

// *** verification/test_chr_can_hist_ts.sv ***
`timescale 1ns/100ps
module test_chr_can_hist_ts;
    localparam RXL = 14'h178, RXP = 14'h180, TXL = 14'h188, TXP = 14'h190, TS = 14'h198, PL = 14'h1c0;
    reg clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, rxs = 0, rxd = 0, txd = 0, auto_block_transmit = 0, sof = 0, eof = 0;
    reg ce = 1;
    reg [13:0] paddr = 14'h0;
    reg [31:0] pwdata = 32'h0, rd;
    reg [4:0]  rb = 5'h0;
    reg        er, s;
    wire [31:0] prdata;
    wire        pready, pslverr, stamp;
    integer fail_count = 0, comparisons = 0, cyc = 0, i;
    chr_can_hist_ts i_chr_can_hist_ts (.core_clk_in(clk), .resetn_in(rst_n), .clk_en_in(ce), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .rx_store_in(rxs), .rx_data_frame_in(rxd), .rx_buf_in(rb),
        .tx_done_in(txd), .tx_buf_in(rb), .auto_block_transmit_in(auto_block_transmit), .sof_event_in(sof), .eof_event_in(eof),
        .stamp_toggle_output_out(stamp));
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count = fail_count + 1;
            $display("MISMATCH t=%0t timeout", $time);
            stop_test;
        end
    end
    ////////////////////////////////////////////////////////////////
    task cmp(input [31:0] got, input [31:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // request held until pready is seen high
    task apb(input w, input [13:0] a, input [31:0] d);
        @(posedge clk); psel <= 1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk); pen <= 1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata; er = pslverr; psel <= 0; pen <= 0;
    endtask
    task rchk(input [13:0] a, input [31:0] m, input [31:0] e);
        apb(0, a, 0); cmp(rd & m, e);
    endtask
    // m = {rx store, tx done, sof, eof}
    task ev(input [3:0] m, input [4:0] b);
        @(posedge clk); {rxs, txd, sof, eof} <= m; rb <= b;
        @(posedge clk); {rxs, txd, sof, eof} <= 4'h0;
    endtask
    task tog(input [3:0] m, input e);
        s = stamp; ev(m, 5'h1); repeat (2) @(posedge clk); cmp(stamp, s ^ e);
    endtask
    ////////////////////////////////////////////////////////////////
    task t_basic;
        rchk(TS, 32'hffffffff, 0);
        rchk(RXP, 3, 2);
        rchk(TXP, 3, 2);
        // a store while the clock enable is low must leave the list untouched
        ce <= 0;
        ev(8, 4);
        ce <= 1;
        rchk(RXP, 3, 2);
        ev(8, 3); ev(8, 17); ev(8, 31);
        rchk(RXL, 32'h1f, 31);
        rchk(RXP, 32'hffff, 32'h0300);
        rchk(RXP, 32'hffff, 32'h1100);
        rchk(RXP, 32'hffff, 32'h1f00);
        rchk(RXP, 3, 2);
        auto_block_transmit <= 1; ev(4, 5);
        rchk(TXP, 3, 2);
        ev(4, 8);
        rchk(TXL, 32'h1f, 8);
        rchk(TXP, 32'hffff, 32'h0800);
        auto_block_transmit <= 0;
        $display("basic lists done");
    endtask
    // n stores overflow the list; early entries must still come out in order
    task t_ovf(input [13:0] a, input [3:0] m, input integer n);
        for (i = 0; i < n; i = i + 1) ev(m, i[4:0]);
        rchk(a - 14'h8, 32'h1f, n - 1);
        rchk(a, 32'h1f03, 1);
        for (i = 1; i < n - 3; i = i + 1) rchk(a, 32'h1f03, {i[4:0], 8'h01});
        for (i = 0; i < 30 && rd[1] !== 1'b1; i = i + 1) apb(0, a, 0);
        cmp(rd[1:0], 3);
        ev(m, 9);
        rchk(a - 14'h8, 32'h1f, 9);
        rchk(a, 3, 3);
        apb(1, a, 0);
        rchk(a, 3, 3);
        apb(1, a, 1);
        rchk(a, 3, 2);
        $display("overflow done");
    endtask
    task t_stamp;
        apb(1, TS, 32'h0100);
        rchk(TS, 32'hffff, 1);
        tog(2, 1);
        tog(1, 0);
        apb(1, TS, 32'h0202);
        rchk(TS, 32'hffff, 1);
        apb(1, TS, 32'h0200);
        tog(1, 1);
        tog(2, 0);
        apb(1, TS, 32'h0001);
        tog(1, 0);
        apb(1, TS, 32'h0500);
        ev(8, 0);
        rchk(TS, 32'hffff, 7);
        s = stamp;
        rxd <= 1;
        ev(9, 0);
        rxd <= 0;
        repeat (2) @(posedge clk);
        cmp(stamp, s);
        rchk(TS, 32'hffff, 6);
        tog(1, 0);
        $display("stamp done");
    endtask
    task t_pay;
        apb(1, PL, 32'h1234);
        rchk(PL + 14'h10, 32'hff, 32'h34);
        rchk(PL + 14'h14, 32'hff, 32'h12);
        apb(1, PL + 14'h2c, 32'ha5);
        rchk(PL + 14'hc, 32'hff00, 32'ha500);
        apb(0, 14'h3fc, 0);
        cmp(er, 1);
        cmp(rd, 0);
        $display("payload done");
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1;
        t_basic;
        t_ovf(RXP, 8, 24);
        t_ovf(TXP, 4, 8);
        t_stamp;
        t_pay;
        stop_test;
    end
endmodule // test_chr_can_hist_ts
